// ### src/ogc_consts.svh
`ifndef OGC_CONSTS_SVH
`define OGC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define OGC_IDX_MOFS0 8'h07
`define OGC_IDX_MOFS1 8'h08
`define OGC_IDX_MOFS2 8'h09
`define OGC_IDX_MGAIN0 8'h0a
`define OGC_IDX_MGAIN1 8'h0b
`define OGC_IDX_MGAIN2 8'h0c
`define OGC_IDX_AOFS0 8'h17
`define OGC_IDX_AOFS1 8'h18
`define OGC_IDX_AGAIN0 8'h19
`define OGC_IDX_AGAIN1 8'h1a
`define OGC_IDX_CTRL 8'h20
`define OGC_IDX_STATUS 8'h21

// ----------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------
`define OGC_CTRL_CHOP 0
`define OGC_CTRL_CAL_LO 1
`define OGC_CTRL_CAL_HI 3
`define OGC_CTRL_START 4
`define OGC_STAT_BUSY 0
`define OGC_STAT_DONE 1
`define OGC_STAT_FULL 2

// ----------------------------------------------------------------
// Reset values and arithmetic constants
// ----------------------------------------------------------------
`define OGC_MOFS_RST 24'h000000
`define OGC_MGAIN_RST 24'h400000
`define OGC_AOFS_RST 16'h0000
`define OGC_AGAIN_RST 16'h4000
`define OGC_MSHIFT 22
`define OGC_ASHIFT 14
`define OGC_CAL_READS 5'h10
`define OGC_FIFO_DEPTH 16

`endif

// ### src/ogc_corrector.sv
`timescale 1ns/1ps
`include "ogc_consts.svh"
module ogc_corrector (
	// Sample
	input wire logic aux,
	input wire logic [31:0] raw,
	// Coefficients
	input wire logic [23:0] mofs,
	input wire logic [23:0] mgain,
	input wire logic [15:0] aofs,
	input wire logic [15:0] again,
	input wire logic chop,
	// Result
	output logic [31:0] result
);
	localparam logic signed [33:0] MAX32 = 34'sh07fffffff;
	localparam logic signed [33:0] MIN32 = -34'sh080000000;
	localparam logic signed [25:0] MAX24 = 26'sh07fffff;
	localparam logic signed [25:0] MIN24 = -26'sh0800000;
	// Offset aligned to the top of the sample, zeroed under chop
	wire signed [32:0] m_ofs = chop ? 33'sh0 : 33'($signed({mofs, 8'h00}));
	wire signed [32:0] m_diff = 33'($signed(raw)) - m_ofs;
	wire signed [57:0] m_prod = m_diff * $signed({1'b0, mgain});
	// Arithmetic shift floors toward minus infinity
	// Full offset span times the largest gain reaches 2^34, so keep 36 bits before clipping
	wire signed [35:0] m_scl = 36'(m_prod >>> `OGC_MSHIFT);
	wire signed [24:0] a_ofs = 25'($signed({aofs, 8'h00}));
	wire signed [24:0] a_diff = 25'($signed(raw[23:0])) - a_ofs;
	wire signed [41:0] a_prod = a_diff * $signed({1'b0, again});
	wire signed [27:0] a_scl = 28'(a_prod >>> `OGC_ASHIFT);
	wire [31:0] m_sat = (m_scl > MAX32) ? 32'h7fffffff :
		(m_scl < MIN32) ? 32'h80000000 : m_scl[31:0];
	wire [23:0] a_sat = (a_scl > MAX24) ? 24'h7fffff :
		(a_scl < MIN24) ? 24'h800000 : a_scl[23:0];
	assign result = aux ? {{8{a_sat[23]}}, a_sat} : m_sat;
endmodule : ogc_corrector

// ### src/ogc_fifo.sv
`timescale 1ns/1ps
module ogc_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic [AW:0] cnt_nxt;
	// Ready is kept in a flop so the sample port is driven straight from a register
	logic rdy_r;
	wire do_wr = in_valid && in_ready;
	wire do_rd = out_valid && out_ready;

	assign in_ready = rdy_r;
	assign cnt_nxt = cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];

	always_ff @(posedge pclk)
		if (do_wr)
			mem[wr_r] <= in_data;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b1;
		end
		else
		begin
			if (do_wr)
				wr_r <= wr_r + 1'b1;
			if (do_rd)
				rd_r <= rd_r + 1'b1;
			cnt_r <= cnt_nxt;
			rdy_r <= (cnt_nxt != (AW+1)'(DEPTH));
		end
endmodule : ogc_fifo

// ### src/ogc_pkg.sv
package ogc_pkg;

	typedef enum logic [2:0] {
		OGC_CAL_NONE = 3'b000,
		OGC_CAL_MOFS = 3'b001,
		OGC_CAL_MGAIN = 3'b010,
		OGC_CAL_AOFS = 3'b011,
		OGC_CAL_AGAIN = 3'b100
	} ogc_cal_t;

	typedef enum logic [1:0] {
		OGC_ST_IDLE = 2'b00,
		OGC_ST_ACC = 2'b01,
		OGC_ST_LOAD = 2'b10
	} ogc_state_t;

	// One filter sample: which channel and its raw value
	typedef struct packed {
		logic aux;
		logic [31:0] data;
	} ogc_sample_t;

endpackage : ogc_pkg

// ### src/ogc_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "ogc_consts.svh"
module ogc_top (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Filter samples in
	input wire logic smp_valid,
	output logic smp_ready,
	input wire logic smp_aux,
	input wire logic [31:0] smp_data,
	// Corrected results out
	output logic res_valid,
	input wire logic res_ready,
	output logic res_aux,
	output logic [31:0] res_data
);
	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	wire apb_acc = psel && penable;
	// Writes land once, at the completing edge only
	wire apb_wr = apb_acc && pwrite && pready;
	wire [7:0] idx = paddr[9:2];
	wire aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	wire hit_mofs0 = aligned && idx == `OGC_IDX_MOFS0;
	wire hit_mofs1 = aligned && idx == `OGC_IDX_MOFS1;
	wire hit_mofs2 = aligned && idx == `OGC_IDX_MOFS2;
	wire hit_mg0 = aligned && idx == `OGC_IDX_MGAIN0;
	wire hit_mg1 = aligned && idx == `OGC_IDX_MGAIN1;
	wire hit_mg2 = aligned && idx == `OGC_IDX_MGAIN2;
	wire hit_aofs0 = aligned && idx == `OGC_IDX_AOFS0;
	wire hit_aofs1 = aligned && idx == `OGC_IDX_AOFS1;
	wire hit_ag0 = aligned && idx == `OGC_IDX_AGAIN0;
	wire hit_ag1 = aligned && idx == `OGC_IDX_AGAIN1;
	wire hit_ctrl = aligned && idx == `OGC_IDX_CTRL;
	wire hit_stat = aligned && idx == `OGC_IDX_STATUS;
	wire hit_any = hit_mofs0 || hit_mofs1 || hit_mofs2 || hit_mg0 || hit_mg1 || hit_mg2 ||
		hit_aofs0 || hit_aofs1 || hit_ag0 || hit_ag1 || hit_ctrl || hit_stat;

	// ----------------------------------------------------------------
	// Coefficient and control state
	// ----------------------------------------------------------------
	logic [23:0] mofs_r;
	logic [23:0] mgain_r;
	logic [15:0] aofs_r;
	logic [15:0] again_r;
	logic chop_r;
	logic done_r;
	ogc_pkg::ogc_cal_t cal_r;
	ogc_pkg::ogc_state_t st_r;
	logic [4:0] cnt_r;
	logic signed [35:0] acc_r;

	// Software write or calibration load into each word
	wire cal_load = (st_r == ogc_pkg::OGC_ST_LOAD);
	wire start_req = apb_wr && hit_ctrl && pwdata[`OGC_CTRL_START] &&
		(st_r == ogc_pkg::OGC_ST_IDLE);
	wire [2:0] start_kind = pwdata[`OGC_CTRL_CAL_HI:`OGC_CTRL_CAL_LO];

	// ----------------------------------------------------------------
	// Data path: FIFO then correction then output register
	// ----------------------------------------------------------------
	ogc_pkg::ogc_sample_t in_s;
	ogc_pkg::ogc_sample_t fifo_s;
	logic fifo_valid;
	logic fifo_full_n;
	logic [32:0] fifo_q;
	logic [31:0] corr;

	assign in_s.aux = smp_aux;
	assign in_s.data = smp_data;
	assign fifo_s = ogc_pkg::ogc_sample_t'(fifo_q);

	// Coefficients are reloaded at the end of a load cycle, so the stage stalls then
	logic drain;
	assign drain = fifo_valid && (!res_valid || res_ready) && !cal_load;

	ogc_fifo #(
		.WIDTH(33),
		.DEPTH(`OGC_FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(smp_valid),
		.in_ready(fifo_full_n),
		.in_data(in_s),
		.out_valid(fifo_valid),
		.out_ready(drain),
		.out_data(fifo_q)
	);

	assign smp_ready = fifo_full_n;

	// Calibration sees the sample raw for offset, offset-corrected for gain
	wire cal_gain = (cal_r == ogc_pkg::OGC_CAL_MGAIN) || (cal_r == ogc_pkg::OGC_CAL_AGAIN);
	wire cal_aux = (cal_r == ogc_pkg::OGC_CAL_AOFS) || (cal_r == ogc_pkg::OGC_CAL_AGAIN);
	wire cal_acc = (st_r == ogc_pkg::OGC_ST_ACC);
	wire cal_take = drain && cal_acc && (fifo_s.aux == cal_aux);
	// Unity gain only while readings are gathered; afterwards the loaded word applies
	wire [23:0] gain_m_eff = (cal_acc && cal_r == ogc_pkg::OGC_CAL_MGAIN) ?
		`OGC_MGAIN_RST : mgain_r;
	wire [15:0] gain_a_eff = (cal_acc && cal_r == ogc_pkg::OGC_CAL_AGAIN) ?
		`OGC_AGAIN_RST : again_r;

	ogc_corrector u_corr (
		.aux(fifo_s.aux),
		.raw(fifo_s.data),
		.mofs(mofs_r),
		.mgain(gain_m_eff),
		.aofs(aofs_r),
		.again(gain_a_eff),
		.chop(chop_r),
		.result(corr)
	);

	wire [31:0] cal_src = cal_gain ? corr : fifo_s.data;
	wire signed [35:0] cal_ext = cal_aux ? 36'($signed(cal_src[23:0])) : 36'($signed(cal_src));
	wire signed [31:0] cal_avg = 32'(acc_r >>> 4);
	// Gain word = unity * fullscale / average; one divider per channel, both over the shared denominator
	wire [31:0] cal_den = (cal_avg > 32'sd0) ? cal_avg : 32'h00000001;
	wire [54:0] m_gnum = 55'h7fffffff << `OGC_MSHIFT;
	wire [54:0] a_gnum = 55'h7fffff << `OGC_ASHIFT;
	wire [54:0] m_gq = m_gnum / 55'(cal_den);
	wire [54:0] a_gq = a_gnum / 55'(cal_den);
	wire [23:0] m_gsat = (m_gq > 55'hffffff) ? 24'hffffff : m_gq[23:0];
	wire [15:0] a_gsat = (a_gq > 55'hffff) ? 16'hffff : a_gq[15:0];

	// ----------------------------------------------------------------
	// Calibration sequencer
	// ----------------------------------------------------------------
	ogc_pkg::ogc_state_t st_nxt;
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			ogc_pkg::OGC_ST_IDLE:
				if (start_req && start_kind != 3'b000 && start_kind <= 3'b100)
					st_nxt = ogc_pkg::OGC_ST_ACC;
			ogc_pkg::OGC_ST_ACC:
				if (cal_take && cnt_r == `OGC_CAL_READS - 5'h01)
					st_nxt = ogc_pkg::OGC_ST_LOAD;
			ogc_pkg::OGC_ST_LOAD:
				st_nxt = ogc_pkg::OGC_ST_IDLE;
			default:
				st_nxt = ogc_pkg::OGC_ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			st_r <= ogc_pkg::OGC_ST_IDLE;
			cal_r <= ogc_pkg::OGC_CAL_NONE;
			cnt_r <= 5'h00;
			acc_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			if (start_req)
			begin
				cal_r <= ogc_pkg::ogc_cal_t'(start_kind);
				cnt_r <= 5'h00;
				acc_r <= '0;
			end
			else if (cal_take)
			begin
				cnt_r <= cnt_r + 5'h01;
				acc_r <= acc_r + cal_ext;
			end
		end

	// ----------------------------------------------------------------
	// Coefficient registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mofs_r <= `OGC_MOFS_RST;
			mgain_r <= `OGC_MGAIN_RST;
			aofs_r <= `OGC_AOFS_RST;
			again_r <= `OGC_AGAIN_RST;
			chop_r <= 1'b0;
		end
		else if (cal_load)
		begin
			unique case (cal_r)
				ogc_pkg::OGC_CAL_MOFS: mofs_r <= cal_avg[31:8];
				ogc_pkg::OGC_CAL_MGAIN: mgain_r <= m_gsat;
				ogc_pkg::OGC_CAL_AOFS: aofs_r <= cal_avg[23:8];
				ogc_pkg::OGC_CAL_AGAIN: again_r <= a_gsat;
				default: ;
			endcase
		end
		else if (apb_wr)
		begin
			if (hit_mofs0) mofs_r[7:0] <= pwdata[7:0];
			if (hit_mofs1) mofs_r[15:8] <= pwdata[7:0];
			if (hit_mofs2) mofs_r[23:16] <= pwdata[7:0];
			if (hit_mg0) mgain_r[7:0] <= pwdata[7:0];
			if (hit_mg1) mgain_r[15:8] <= pwdata[7:0];
			if (hit_mg2) mgain_r[23:16] <= pwdata[7:0];
			if (hit_aofs0) aofs_r[7:0] <= pwdata[7:0];
			if (hit_aofs1) aofs_r[15:8] <= pwdata[7:0];
			if (hit_ag0) again_r[7:0] <= pwdata[7:0];
			if (hit_ag1) again_r[15:8] <= pwdata[7:0];
			if (hit_ctrl) chop_r <= pwdata[`OGC_CTRL_CHOP];
		end

	// Done is sticky; a new load wins over a clear in the same cycle
	wire done_clr = apb_wr && hit_stat && pwdata[`OGC_STAT_DONE];
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			done_r <= 1'b0;
		else
			done_r <= cal_load || (done_r && !done_clr);

	// ----------------------------------------------------------------
	// Read mux and APB answer
	// ----------------------------------------------------------------
	wire [7:0] stat_byte = {5'h00, !fifo_full_n, done_r, st_r != ogc_pkg::OGC_ST_IDLE};
	wire [7:0] ctrl_byte = {4'h0, cal_r, chop_r};
	wire [7:0] rd_byte =
		hit_mofs0 ? mofs_r[7:0] : hit_mofs1 ? mofs_r[15:8] : hit_mofs2 ? mofs_r[23:16] :
		hit_mg0 ? mgain_r[7:0] : hit_mg1 ? mgain_r[15:8] : hit_mg2 ? mgain_r[23:16] :
		hit_aofs0 ? aofs_r[7:0] : hit_aofs1 ? aofs_r[15:8] :
		hit_ag0 ? again_r[7:0] : hit_ag1 ? again_r[15:8] :
		hit_ctrl ? ctrl_byte : hit_stat ? stat_byte : 8'h00;

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= apb_acc && !pready;
			prdata <= (apb_acc && !pready && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
			pslverr <= apb_acc && !pready && !hit_any;
		end

	// ----------------------------------------------------------------
	// Result register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			res_valid <= 1'b0;
			res_aux <= 1'b0;
			res_data <= 32'h00000000;
		end
		else if (drain)
		begin
			res_valid <= 1'b1;
			res_aux <= fifo_s.aux;
			res_data <= corr;
		end
		else if (res_ready)
			res_valid <= 1'b0;

	// Main product rebuilt from the stored words, to tell when clipping high is due
	wire signed [32:0] ref_ofs = chop_r ? 33'sh0 : 33'($signed({mofs_r, 8'h00}));
	wire signed [32:0] ref_diff = 33'($signed(fifo_s.data)) - ref_ofs;
	wire signed [57:0] ref_prod = ref_diff * $signed({1'b0, gain_m_eff});
	wire m_scl_hi = (ref_prod >>> `OGC_MSHIFT) > 58'sh07fffffff;
	wire rd_first = apb_acc && !pready && !pwrite;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_zero_ofs_pass: assert property (@(posedge pclk) disable iff (!presetn)
		(drain && !fifo_s.aux && mofs_r == 24'h0 && gain_m_eff == 24'h400000)
		|=> res_data == $past(fifo_s.data))
		else $error("zero offset at unity gain altered the sample");
	chk_chop_bypass: assert property (@(posedge pclk) disable iff (!presetn)
		(drain && !fifo_s.aux && chop_r && gain_m_eff == 24'h400000)
		|=> res_data == $past(fifo_s.data))
		else $error("chop mode did not bypass offset");
	chk_main_sat: assert property (@(posedge pclk) disable iff (!presetn)
		(drain && !fifo_s.aux && m_scl_hi) |=> res_data == 32'h7fffffff)
		else $error("main result not clipped high");
	chk_mofs_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_wr && hit_mofs2 && !cal_load) |=> mofs_r[23:16] == $past(pwdata[7:0]))
		else $error("main offset high byte not written");
	chk_mgain_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_wr && hit_mg0 && !cal_load) |=> mgain_r[7:0] == $past(pwdata[7:0]))
		else $error("main gain low byte not written");
	chk_aofs_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_wr && hit_aofs1 && !cal_load) |=> aofs_r[15:8] == $past(pwdata[7:0]))
		else $error("aux offset high byte not written");
	chk_again_write: assert property (@(posedge pclk) disable iff (!presetn)
		(apb_wr && hit_ag1 && !cal_load) |=> again_r[15:8] == $past(pwdata[7:0]))
		else $error("aux gain high byte not written");
	sequence s_cal_acc;
		st_r == ogc_pkg::OGC_ST_ACC && cal_take && cnt_r == 5'h0f;
	endsequence
	chk_cal_load: assert property (@(posedge pclk) disable iff (!presetn)
		s_cal_acc |=> cal_load ##1 (st_r == ogc_pkg::OGC_ST_IDLE && done_r))
		else $error("calibration did not load after sixteen readings");
	chk_aux_unity: assert property (@(posedge pclk) disable iff (!presetn)
		(drain && fifo_s.aux && aofs_r == 16'h0000 && gain_a_eff == 16'h4000)
		|=> res_data == 32'($signed($past(fifo_s.data[23:0]))))
		else $error("aux zero offset at unity gain altered the sample");
	chk_mofs_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_first && hit_mofs0)
		|=> prdata == {24'h000000, $past(mofs_r[7:0])})
		else $error("main offset low byte read back wrong");
	chk_again_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_first && hit_ag1)
		|=> prdata == {24'h000000, $past(again_r[15:8])})
		else $error("aux gain high byte read back wrong");
	chk_ofs_cal_load: assert property (@(posedge pclk) disable iff (!presetn)
		(cal_load && cal_r == ogc_pkg::OGC_CAL_MOFS)
		|=> mofs_r == $past(cal_avg[31:8]))
		else $error("main offset calibration result not loaded");
	chk_gain_cal_load: assert property (@(posedge pclk) disable iff (!presetn)
		(cal_load && cal_r == ogc_pkg::OGC_CAL_MGAIN)
		|=> mgain_r == $past(m_gsat))
		else $error("main gain calibration result not loaded");
	chk_res_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(res_valid && !res_ready)
		|=> (res_valid && $stable(res_data) && $stable(res_aux)))
		else $error("result changed while the consumer stalled");
endmodule : ogc_top

// ### tb/testbench.sv
`timescale 1ns/1ps
`include "ogc_consts.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic smp_valid = 1'b0;
	logic smp_ready;
	logic smp_aux = 1'b0;
	logic [31:0] smp_data = 32'h00000000;
	logic res_valid;
	logic res_ready = 1'b0;
	logic res_aux;
	logic [31:0] res_data;
	int error_cnt = 0;
	int comparisons = 0;
	int rr_mode = 0;
	int n;
	logic ok;
	logic err;
	logic [31:0] rd;
	logic [31:0] v;
	logic chop_m = 1'b0;
	// Model copy of the words: aux gain, aux offset, main gain, main offset
	logic [79:0] words;
	logic [79:0] unity = {16'h4000, 16'h0000, 24'h400000, 24'h000000};
	logic [32:0] exp_q [$];
	logic [7:0] idx_tab [10] = '{`OGC_IDX_MOFS0, `OGC_IDX_MOFS1, `OGC_IDX_MOFS2,
		`OGC_IDX_MGAIN0, `OGC_IDX_MGAIN1, `OGC_IDX_MGAIN2, `OGC_IDX_AOFS0,
		`OGC_IDX_AOFS1, `OGC_IDX_AGAIN0, `OGC_IDX_AGAIN1};
	logic [80:0] sets [6] = '{{1'b0, 16'h4000, 16'h0000, 24'h400000, 24'h000000},
		{1'b1, 16'h4000, 16'h0100, 24'h400000, 24'h654321},
		{1'b0, 16'h4000, 16'h7fff, 24'h400000, 24'h7fffff},
		{1'b0, 16'hffff, 16'h8000, 24'hffffff, 24'h800000},
		{1'b0, 16'h3ccc, 16'h0001, 24'h3ccccc, 24'h000001},
		{1'b1, 16'h5000, 16'h1234, 24'h433333, 24'h123456}};

	ogc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_aux(smp_aux),
		.smp_data(smp_data), .res_valid(res_valid), .res_ready(res_ready), .res_aux(res_aux),
		.res_data(res_data));

	initial forever #25 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Checking and reference model
	// ----------------------------------------------------------------
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [31:0] model(input logic a, input logic [31:0] d);
		longint x;
		longint lim;
		if (a)
		begin
			x = longint'(signed'(d[23:0])) - longint'(signed'(words[63:48])) * 256;
			x = (x * longint'(words[79:64])) >>> `OGC_ASHIFT;
			lim = 64'sh7fffff;
		end
		else
		begin
			x = longint'(signed'(d)) - (chop_m ? 0 : longint'(signed'(words[23:0])) * 256);
			x = (x * longint'(words[47:24])) >>> `OGC_MSHIFT;
			lim = 64'sh7fffffff;
		end
		if (x > lim)
			x = lim;
		if (x < -lim - 1)
			x = -lim - 1;
		return x[31:0];
	endfunction : model

	always @(posedge pclk)
	begin
		if (res_valid === 1'b1 && res_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk(res_data, 64'hdead);
			else
				chk({res_aux, res_data}, exp_q.pop_front());
		end
		res_ready <= (rr_mode == 0) || (rr_mode == 1 && $urandom % 3 != 0);
	end

	// ----------------------------------------------------------------
	// Bus and stream drivers
	// ----------------------------------------------------------------
	task apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] r, output logic e);
		int k;
		k = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20)
		begin
			@(posedge pclk);
			k++;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20)
			chk(0, 1);
		@(posedge pclk);
	endtask : apb

	task prog(input logic [80:0] s);
		words = s[79:0];
		chop_m = s[80];
		for (int i = 0; i < 10; i++)
			apb(1'b1, idx_tab[i], words[8*i +: 8], rd, err);
		apb(1'b1, `OGC_IDX_CTRL, {7'h0, chop_m}, rd, err);
	endtask : prog

	task rdall;
		for (int i = 0; i < 10; i++)
		begin
			apb(1'b0, idx_tab[i], 8'h00, rd, err);
			chk({err, rd}, {25'h0, words[8*i +: 8]});
		end
	endtask : rdall

	// Leaves valid up on success so that pushes can run back to back
	task push(input logic a, input logic [31:0] d, input int maxw, output logic acc);
		int k;
		k = 0;
		acc = 1'b0;
		smp_valid <= 1'b1;
		smp_aux <= a;
		smp_data <= d;
		while (!acc && k < maxw)
		begin
			@(posedge pclk);
			k++;
			if (smp_ready === 1'b1)
			begin
				acc = 1'b1;
				exp_q.push_back({a, model(a, d)});
			end
		end
		if (!acc)
			smp_valid <= 1'b0;
	endtask : push

	task drain;
		int k;
		k = 0;
		smp_valid <= 1'b0;
		while (exp_q.size() != 0 && k < 3000)
		begin
			@(posedge pclk);
			k++;
		end
		chk(exp_q.size(), 0);
	endtask : drain

	task batch(input int cnt);
		logic [31:0] d;
		for (int i = 0; i < cnt; i++)
		begin
			case ($urandom % 4)
				0: d = 32'h7fffffff;
				1: d = 32'h80000000;
				default: d = $urandom;
			endcase
			push(1'($urandom % 2), d, 300, ok);
			chk(ok, 1'b1);
		end
		drain;
	endtask : batch

	task results;
		$display("Comparisons %0d, errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	initial
	begin
		repeat (40000) @(posedge pclk);
		error_cnt++;
		results;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(89));
		words = unity;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdall;
		apb(1'b1, 8'h05, 8'hff, rd, err);
		chk(err, 1'b1);
		apb(1'b0, 8'h05, 8'h00, rd, err);
		chk({err, rd}, {1'b1, 32'h0});
		prog({1'b0, 16'($urandom), 16'($urandom), 24'($urandom), 24'($urandom)});
		rdall;
		rr_mode = 1;
		batch(24);
		for (int s = 0; s < 6; s++)
		begin
			prog(sets[s]);
			batch(24);
		end
		// Stall the consumer so the buffer backs up and refuses
		rr_mode = 2;
		repeat (3) @(posedge pclk);
		n = 0;
		ok = 1'b1;
		while (ok && n < 40)
		begin
			push(1'b0, $urandom, 30, ok);
			if (ok)
				n++;
		end
		chk(n >= 16, 1'b1);
		chk(smp_ready, 1'b0);
		apb(1'b0, `OGC_IDX_STATUS, 8'h00, rd, err);
		chk(rd[`OGC_STAT_FULL], 1'b1);
		rr_mode = 1;
		drain;
		// Main offset, main gain, aux offset, aux gain, each from 16 equal readings
		for (int c = 0; c < 4; c++)
		begin
			prog({1'b0, unity});
			v = $urandom;
			// Gain readings stay positive and large enough to avoid a clipped word
			if (c % 2)
				v = {2'b01, v[29:24], 2'b01, v[21:0]};
			apb(1'b1, `OGC_IDX_CTRL, 8'h10 | 8'((c + 1) << 1), rd, err);
			for (int i = 0; i < 16; i++)
				push(c >= 2, v, 300, ok);
			drain;
			n = 0;
			rd = 32'h0;
			while (rd[`OGC_STAT_DONE] !== 1'b1 && n < 100)
			begin
				apb(1'b0, `OGC_IDX_STATUS, 8'h00, rd, err);
				n++;
			end
			chk(rd[`OGC_STAT_DONE], 1'b1);
			apb(1'b1, `OGC_IDX_STATUS, 8'h02, rd, err);
			apb(1'b0, `OGC_IDX_STATUS, 8'h00, rd, err);
			chk(rd[`OGC_STAT_DONE], 1'b0);
			case (c)
				0: words[23:0] = v[31:8];
				1: words[47:24] = 24'((64'h7fffffff << `OGC_MSHIFT) / v);
				2: words[63:48] = v[23:8];
				default: words[79:64] = 16'((64'h7fffff << `OGC_ASHIFT) / v[23:0]);
			endcase
			rdall;
			repeat (20) @(posedge pclk);
			exp_q.delete();
			batch(8);
		end
		results;
	end
endmodule : testbench
